/* File: pot_dev_model.sv */
// behavioural four-pot device answering on the serial link
`timescale 1ns/1ps
module pot_dev_model #(
    parameter logic [3:0] TYPE_ID   = 4'hA, // arbitrary value
    parameter logic [1:0] CHIP_ADDR = 2'h1
) (
    // serial pins
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so
);
    logic [7:0]  wiper [4];
    logic [7:0]  stored [4][4];
    logic [15:0] head;
    logic [7:0]  rd;
    logic [7:0]  wr;
    logic        nv_busy;
    int          n;
    wire  [3:0]  op  = head[7:4];
    wire  [1:0]  bk  = head[3:2];
    wire  [1:0]  pt  = head[1:0];
    wire         hit = head[15:8] == {TYPE_ID, 2'b00, CHIP_ADDR};
    initial begin
        so = 1'b0;
        nv_busy = 1'b0;
        for (int b = 0; b < 4; b++)
            for (int p = 0; p < 4; p++) begin
                stored[b][p] = 8'(16 * b + p);
                wiper[p] = 8'(p);
            end
    end
    always @(negedge cs_n) n = 0;
    always @(posedge sck) if (!cs_n) begin
        if (n < 16)
            head = {head[14:0], si};
        else if (hit && op == 4'h2) begin
            if (si && wiper[pt] != 8'hFF) wiper[pt] = wiper[pt] + 8'h01;
            if (!si && wiper[pt] != 8'h00) wiper[pt] = wiper[pt] - 8'h01;
        end else
            wr = {wr[6:0], si};
        n = n + 1;
    end
    // released output shows the inverse of its last level, never a stale bit
    always @(negedge sck) begin
        if (n == 16) rd = (op == 4'hB) ? stored[bk][pt] : wiper[pt];
        if (!cs_n && hit && n >= 16 && (op == 4'h9 || op == 4'hB)) begin
            so <= rd[7];
            rd = {rd[6:0], 1'b0};
        end else
            so <= ~so;
    end
    // at release only frames of the exact length take effect; step frames act on each clock past the head
    always @(posedge cs_n) if (hit) begin
        so <= ~so;
        if (n == 24 && op == 4'hA) wiper[pt] = wr;
        if (n == 24 && op == 4'hC) stored[bk][pt] = wr;
        if (n == 16 && op == 4'hD) wiper[pt] = stored[bk][pt];
        if (n == 16 && op == 4'hE) stored[bk][pt] = wiper[pt];
        for (int i = 0; i < 4; i++) begin
            if (n == 16 && op == 4'h1) wiper[i] = stored[bk][i];
            if (n == 16 && op == 4'h8) stored[bk][i] = wiper[i];
        end
        if ((n == 24 && op == 4'hC) || (n == 16 && (op == 4'hE || op == 4'h8))) begin
            nv_busy = 1'b1;
            nv_busy <= #20000 1'b0;
        end
    end
endmodule

/* File: quad_pot_host.sv */
// serial host for the quad potentiometer with an axi4-lite command port
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module quad_pot_host
    import quad_pot_pkg::*;
#(
    parameter int         HALF_CYCLES    = SCK_HALF_CYCLES,
    parameter logic [3:0] DEVICE_TYPE_ID = 4'hA  // arbitrary value
) (
    // clock, reset, enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // axi4-lite write channels
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read channels
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // serial pins
    output logic                   sck,
    output logic                   cs_n,
    output logic                   si,
    input  wire logic              so,
    output logic                   hold_n
);

    // bus state
    logic              aw_held_q, aw_held_d;
    logic [ADDR_W-1:0] awaddr_q,  awaddr_d;
    logic              w_held_q,  w_held_d;
    logic [DATA_W-1:0] wdata_q,   wdata_d;
    logic [3:0]        wstrb_q,   wstrb_d;
    logic              awready_q, awready_d;
    logic              wready_q,  wready_d;
    logic              bvalid_q,  bvalid_d;
    logic [1:0]        bresp_q,   bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q,  rvalid_d;
    logic [DATA_W-1:0] rdata_q,   rdata_d;
    logic [1:0]        rresp_q,   rresp_d;
    logic [31:0]       cmd_q,     cmd_d;
    logic [1:0]        chip_addr_q, chip_addr_d;
    logic              cmd_start;
    logic [DATA_W-1:0] status_word;

    // link state
    link_state_t       state_q,   state_d;
    logic [7:0]        timer_q,   timer_d;
    logic [8:0]        bits_q,    bits_d;
    logic [8:0]        total_q,   total_d;
    logic [23:0]       shift_q,   shift_d;
    logic [7:0]        rx_q,      rx_d;
    logic [3:0]        op_q,      op_d;
    logic              step_q,    step_d;
    logic              dir_q,     dir_d;
    logic              done_q,    done_d;
    logic              reject_q,  reject_d;
    logic              nv_q,      nv_d;
    logic              sck_q,     sck_d;
    logic              cs_n_q,    cs_n_d;
    logic              si_q,      si_d;
    logic              so_meta_q;
    logic              so_sync_q;
    logic              hold_n_q;
    logic              half_end;
    logic [7:0]        byte1;
    logic [1:0]        f_bank;
    logic [1:0]        f_pot;
    logic [3:0]        f_op;

    assign status_word = {16'h0000, rx_q, 4'h0, nv_q, reject_q, done_q, (state_q != LK_IDLE)};

    // ------------------------------------------------------------ register bus
    always_comb begin
        aw_held_d   = aw_held_q;
        awaddr_d    = awaddr_q;
        w_held_d    = w_held_q;
        wdata_d     = wdata_q;
        wstrb_d     = wstrb_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        rvalid_d    = rvalid_q;
        rdata_d     = rdata_q;
        rresp_d     = rresp_q;
        cmd_d       = cmd_q;
        chip_addr_d = chip_addr_q;
        cmd_start   = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // address and data are both parked before the write takes effect
        if (aw_held_q && w_held_q && !bvalid_q) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case (awaddr_q)
                CMD_OFS: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wstrb_q[i]) begin
                            cmd_d[i*8 +: 8] = wdata_q[i*8 +: 8];
                        end
                    end
                    cmd_start = 1'b1;
                end
                CONFIG_OFS: begin
                    if (wstrb_q[0]) begin
                        chip_addr_d = wdata_q[CFG_ADDR_LSB +: 2];
                    end
                end
                STATUS_OFS: begin
                    bresp_d = RESP_OKAY;
                end
                default: begin
                    bresp_d = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (s_axi_araddr)
                CMD_OFS:    rdata_d = cmd_q;
                STATUS_OFS: rdata_d = status_word;
                CONFIG_OFS: rdata_d = {30'h0000_0000, chip_addr_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_held_d;
        wready_d  = !w_held_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q   <= 1'b0;
            awaddr_q    <= '0;
            w_held_q    <= 1'b0;
            wdata_q     <= '0;
            wstrb_q     <= 4'h0;
            awready_q   <= 1'b0;
            wready_q    <= 1'b0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RESP_OKAY;
            arready_q   <= 1'b0;
            rvalid_q    <= 1'b0;
            rdata_q     <= '0;
            rresp_q     <= RESP_OKAY;
            cmd_q       <= CMD_RESET;
            chip_addr_q <= CFG_ADDR_RESET;
        end else if (ce) begin
            aw_held_q   <= aw_held_d;
            awaddr_q    <= awaddr_d;
            w_held_q    <= w_held_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            awready_q   <= awready_d;
            wready_q    <= wready_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            arready_q   <= arready_d;
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
            cmd_q       <= cmd_d;
            chip_addr_q <= chip_addr_d;
        end
    end

    // ------------------------------------------------------------ serial link
    assign half_end = (timer_q == 8'(HALF_CYCLES - 1));
    assign f_op     = cmd_d[CMD_OP_LSB +: 4];
    assign f_bank   = cmd_d[CMD_BANK_LSB +: 2];
    assign f_pot    = cmd_d[CMD_POT_LSB +: 2];

    // the host forces the fixed zero fields so software cannot send a malformed frame
    always_comb begin
        case (f_op)
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP: byte1 = {f_op, 2'b00, f_pot};
            OP_ALL_TO_WIPER, OP_ALL_TO_STORE:  byte1 = {f_op, f_bank, 2'b00};
            default:                           byte1 = {f_op, f_bank, f_pot};
        endcase
    end

    always_comb begin
        state_d  = state_q;
        timer_d  = timer_q;
        bits_d   = bits_q;
        total_d  = total_q;
        shift_d  = shift_q;
        rx_d     = rx_q;
        op_d     = op_q;
        step_d   = step_q;
        dir_d    = dir_q;
        done_d   = done_q;
        reject_d = reject_q;
        nv_d     = nv_q;
        sck_d    = sck_q;
        cs_n_d   = cs_n_q;
        si_d     = si_q;
        case (state_q)
            LK_IDLE: begin
                sck_d  = 1'b0;
                cs_n_d = 1'b1;
                // a command written while a frame runs is dropped; status shows busy
                if (cmd_start) begin
                    op_d    = f_op;
                    step_d  = (f_op == OP_STEP);
                    dir_d   = cmd_d[CMD_DIR_BIT];
                    shift_d = {DEVICE_TYPE_ID, 2'b00, chip_addr_q, byte1, cmd_d[CMD_DATA_LSB +: 8]};
                    bits_d  = 9'h000;
                    timer_d = 8'h00;
                    rx_d    = 8'h00;
                    done_d  = 1'b0;
                    nv_d    = 1'b0;
                    case (f_op)
                        OP_RD_WIPER, OP_WR_WIPER, OP_RD_STORED, OP_WR_STORED: begin
                            total_d  = DATA_BITS;
                            reject_d = 1'b0;
                        end
                        OP_TO_WIPER, OP_TO_STORED, OP_ALL_TO_WIPER, OP_ALL_TO_STORE: begin
                            total_d  = HEAD_BITS;
                            reject_d = 1'b0;
                        end
                        OP_STEP: begin
                            total_d  = HEAD_BITS + {1'b0, cmd_d[CMD_STEPS_LSB +: 8]};
                            reject_d = 1'b0;
                        end
                        default: begin
                            reject_d = 1'b1;
                        end
                    endcase
                    if (reject_d == 1'b0) begin
                        state_d = LK_LOW;
                        cs_n_d  = 1'b0;
                        si_d    = shift_d[23];
                    end
                end
            end
            LK_LOW: begin
                timer_d = timer_q + 8'h01;
                if (half_end) begin
                    timer_d = 8'h00;
                    sck_d   = 1'b1;
                    state_d = LK_HIGH;
                end
            end
            LK_HIGH: begin
                timer_d = timer_q + 8'h01;
                if (half_end) begin
                    timer_d = 8'h00;
                    sck_d   = 1'b0;
                    bits_d  = bits_q + 9'h001;
                    shift_d = {shift_q[22:0], 1'b0};
                    // late in the high phase the device's falling-edge output has settled
                    if (bits_q >= HEAD_BITS) begin
                        rx_d = {rx_q[6:0], so_sync_q};
                    end
                    if (bits_d == total_q) begin
                        state_d = LK_FINISH;
                        si_d    = 1'b0;
                    end else begin
                        state_d = LK_LOW;
                        si_d    = (step_q && bits_d >= HEAD_BITS) ? dir_q : shift_q[22];
                    end
                end
            end
            LK_FINISH: begin
                timer_d = timer_q + 8'h01;
                if (half_end) begin
                    timer_d = 8'h00;
                    cs_n_d  = 1'b1;
                    done_d  = 1'b1;
                    // the device's write-in-progress flag is not polled here
                    nv_d    = (op_q == OP_WR_STORED) || (op_q == OP_TO_STORED) || (op_q == OP_ALL_TO_STORE);
                    state_d = LK_IDLE;
                end
            end
            default: begin
                state_d = LK_IDLE;
                cs_n_d  = 1'b1;
                sck_d   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= LK_IDLE;
            timer_q   <= 8'h00;
            bits_q    <= 9'h000;
            total_q   <= 9'h000;
            shift_q   <= 24'h00_0000;
            rx_q      <= 8'h00;
            op_q      <= 4'h0;
            step_q    <= 1'b0;
            dir_q     <= 1'b0;
            done_q    <= 1'b0;
            reject_q  <= 1'b0;
            nv_q      <= 1'b0;
            sck_q     <= 1'b0;
            cs_n_q    <= 1'b1;
            si_q      <= 1'b0;
            so_meta_q <= 1'b0;
            so_sync_q <= 1'b0;
            hold_n_q  <= 1'b1;
        end else if (ce) begin
            state_q   <= state_d;
            timer_q   <= timer_d;
            bits_q    <= bits_d;
            total_q   <= total_d;
            shift_q   <= shift_d;
            rx_q      <= rx_d;
            op_q      <= op_d;
            step_q    <= step_d;
            dir_q     <= dir_d;
            done_q    <= done_d;
            reject_q  <= reject_d;
            nv_q      <= nv_d;
            sck_q     <= sck_d;
            cs_n_q    <= cs_n_d;
            si_q      <= si_d;
            so_meta_q <= so;
            so_sync_q <= so_meta_q;
            // pause is never used, so the pin stays released
            hold_n_q  <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign sck           = sck_q;
    assign cs_n          = cs_n_q;
    assign si            = si_q;
    assign hold_n        = hold_n_q;

    // ------------------------------------------------------------ checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_frame_head: assert property ($fell(cs_n_q) |->
        shift_q[23:16] == {DEVICE_TYPE_ID, 2'b00, chip_addr_q} && si_q == shift_q[23])
        else $error("frame head does not carry type id and chip address");
    a_rdwiper_len: assert property ($rose(cs_n_q) && op_q == OP_RD_WIPER |-> bits_q == 9'd24)
        else $error("wiper read frame is not 24 clocks");
    a_wrwiper_zero: assert property ($fell(cs_n_q) && op_q == OP_WR_WIPER |->
        shift_q[11:10] == 2'b00 ##1 (bits_q == 9'd0)[*3])
        else $error("wiper write frame has nonzero bank field");
    a_rdstored_len: assert property ($rose(cs_n_q) && op_q == OP_RD_STORED |-> bits_q == 9'd24)
        else $error("stored read frame is not 24 clocks");
    a_wrstored_nv: assert property ($rose(cs_n_q) && op_q == OP_WR_STORED |-> nv_q && bits_q == 9'd24)
        else $error("stored write did not end with a nonvolatile write");
    a_copy_short: assert property ($rose(cs_n_q) && op_q == OP_TO_WIPER |-> bits_q == 9'd16 && !nv_q)
        else $error("copy to wiper is not a plain two-byte frame");
    a_save_nv: assert property ($rose(cs_n_q) && op_q == OP_TO_STORED |-> nv_q && bits_q == 9'd16)
        else $error("wiper save did not flag a nonvolatile write");
    a_step_len: assert property ($rose(cs_n_q) && op_q == OP_STEP |-> bits_q == total_q && $past(si_q) == 1'b0)
        else $error("step frame length differs from the requested count");
    a_global_load: assert property ($fell(cs_n_q) && op_q == OP_ALL_TO_WIPER |-> shift_q[9:8] == 2'b00)
        else $error("global load frame has nonzero pot field");
    a_global_save: assert property ($rose(cs_n_q) && op_q == OP_ALL_TO_STORE |-> nv_q && bits_q == 9'd16)
        else $error("global save did not flag a nonvolatile write");
    a_step_dir: assert property (sck_q && step_q && bits_q >= 9'd16 && !cs_n_q |-> si_q == dir_q)
        else $error("step data does not hold the requested direction");

    c_wiper_read: cover property ($rose(cs_n_q) && op_q == OP_RD_WIPER);
    c_step_run: cover property ($rose(cs_n_q) && op_q == OP_STEP && bits_q > 9'd17);
    c_rejected: cover property ($rose(reject_q));
    c_nv_write: cover property ($rose(nv_q));

endmodule

/* File: quad_pot_host_tb_top.sv */
// testbench for the quad potentiometer serial host
`timescale 1ns/1ps
module quad_pot_host_tb_top;
    import quad_pot_pkg::*;
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] araddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] st;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic              sck, cs_n, si, so;
    int                num_errors;
    int                cmp_count;

    quad_pot_host i_quad_pot_host (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sck(sck), .cs_n(cs_n), .si(si), .so(so), .hold_n()
    );
    pot_dev_model i_pot_dev_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            $display("unexpected wait: expected answer seen none");
            final_report();
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int   k;
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1 && !aw && !w) break;
        end
        tmo(k, 100);
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic axr(input logic [3:0] a, input logic [1:0] er);
        int   k;
        logic ar;
        ar = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1 && !ar) break;
        end
        tmo(k, 100);
        st = rdata;
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    function automatic logic [31:0] cw(input logic [3:0] op, input logic [1:0] b, input logic [1:0] p,
                                       input logic [7:0] d, input logic [7:0] n, input logic up);
        return {7'h00, up, n, d, p, b, op};
    endfunction

    // launch one frame and poll until the link reports it finished
    task automatic do_cmd(input logic [31:0] c);
        int k;
        axw(CMD_OFS, c, RESP_OKAY);
        for (k = 0; k < 300; k++) begin
            axr(STATUS_OFS, RESP_OKAY);
            if (k == 0) chk("busy", 32'(st[ST_BUSY_BIT]), 32'h1);
            if (st[ST_DONE_BIT] === 1'b1) break;
        end
        tmo(k, 300);
    endtask

    task automatic op_chk(input logic [31:0] c, input logic [3:0] rop, input logic [1:0] b,
                          input logic [1:0] p, input logic [7:0] e);
        do_cmd(c);
        do_cmd(cw(rop, b, p, 8'h00, 8'h00, 1'b0));
        chk("read back", 32'(st[15:8]), 32'(e));
    endtask

    initial begin
        num_errors = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        // responses are always accepted, so back-to-back calls never retoggle the ready lines
        bready = 1'b1;
        rready = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(STATUS_OFS, RESP_OKAY);
        chk("status", st, 32'h0);
        axr(CONFIG_OFS, RESP_OKAY);
        chk("config", st, 32'(CFG_ADDR_RESET));
        axr(4'hC, RESP_SLVERR);
        chk("unmapped", st, 32'h0);
        axw(4'hC, 32'h1, RESP_SLVERR);
        axw(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        axw(CONFIG_OFS, 32'h1, RESP_OKAY);
        op_chk(cw(OP_WR_WIPER, 2'h0, 2'h2, 8'h5A, 8'h00, 1'b0), OP_RD_WIPER, 2'h0, 2'h2, 8'h5A);
        do_cmd(cw(OP_WR_STORED, 2'h3, 2'h1, 8'hC3, 8'h00, 1'b0));
        chk("nv flag", 32'(st[ST_NVWRITE_BIT]), 32'h1);
        op_chk(cw(OP_TO_WIPER, 2'h3, 2'h1, 8'h00, 8'h00, 1'b0), OP_RD_STORED, 2'h3, 2'h1, 8'hC3);
        op_chk(cw(OP_TO_WIPER, 2'h3, 2'h1, 8'h00, 8'h00, 1'b0), OP_RD_WIPER, 2'h0, 2'h1, 8'hC3);
        op_chk(cw(OP_TO_STORED, 2'h1, 2'h2, 8'h00, 8'h00, 1'b0), OP_RD_STORED, 2'h1, 2'h2, 8'h5A);
        op_chk(cw(OP_ALL_TO_WIPER, 2'h1, 2'h0, 8'h00, 8'h00, 1'b0), OP_RD_WIPER, 2'h0, 2'h3, 8'h13);
        op_chk(cw(OP_ALL_TO_STORE, 2'h2, 2'h0, 8'h00, 8'h00, 1'b0), OP_RD_STORED, 2'h2, 2'h0, 8'h10);
        op_chk(cw(OP_STEP, 2'h0, 2'h0, 8'h00, 8'h05, 1'b1), OP_RD_WIPER, 2'h0, 2'h0, 8'h15);
        op_chk(cw(OP_STEP, 2'h0, 2'h0, 8'h00, 8'h03, 1'b0), OP_RD_WIPER, 2'h0, 2'h0, 8'h12);
        do_cmd(cw(OP_WR_WIPER, 2'h0, 2'h1, 8'hFE, 8'h00, 1'b0));
        op_chk(cw(OP_STEP, 2'h0, 2'h1, 8'h00, 8'h04, 1'b1), OP_RD_WIPER, 2'h0, 2'h1, 8'hFF);
        do_cmd(cw(OP_WR_WIPER, 2'h0, 2'h1, 8'h01, 8'h00, 1'b0));
        op_chk(cw(OP_STEP, 2'h0, 2'h1, 8'h00, 8'h03, 1'b0), OP_RD_WIPER, 2'h0, 2'h1, 8'h00);
        axw(CONFIG_OFS, 32'h2, RESP_OKAY);
        do_cmd(cw(OP_WR_WIPER, 2'h0, 2'h3, 8'h77, 8'h00, 1'b0));
        axw(CONFIG_OFS, 32'h1, RESP_OKAY);
        op_chk(cw(OP_RD_WIPER, 2'h0, 2'h3, 8'h00, 8'h00, 1'b0), OP_RD_WIPER, 2'h0, 2'h3, 8'h13);
        // an opcode outside the nine is refused without a frame
        axw(CMD_OFS, cw(4'h5, 2'h0, 2'h1, 8'h00, 8'h00, 1'b0), RESP_OKAY);
        axr(STATUS_OFS, RESP_OKAY);
        chk("rejected", st, 32'h0000_0004);
        axr(CMD_OFS, RESP_OKAY);
        chk("command", st, 32'h0000_0045);
        final_report();
    end
endmodule

/* File: quad_pot_pkg.sv */
// constants, register map and states of the quad potentiometer serial host
package quad_pot_pkg;
    // register bus geometry
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam logic [3:0]  CMD_OFS         = 4'h0;
    localparam logic [3:0]  STATUS_OFS      = 4'h4;
    localparam logic [3:0]  CONFIG_OFS      = 4'h8;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // command register fields
    localparam int          CMD_OP_LSB      = 0;
    localparam int          CMD_BANK_LSB    = 4;
    localparam int          CMD_POT_LSB     = 6;
    localparam int          CMD_DATA_LSB    = 8;
    localparam int          CMD_STEPS_LSB   = 16;
    localparam int          CMD_DIR_BIT     = 24;
    localparam logic [31:0] CMD_RESET       = 32'h0000_0000;
    // status register fields
    localparam int          ST_BUSY_BIT     = 0;
    localparam int          ST_DONE_BIT     = 1;
    localparam int          ST_REJECT_BIT   = 2;
    localparam int          ST_NVWRITE_BIT  = 3;
    localparam int          ST_RX_LSB       = 8;
    // config register fields
    localparam int          CFG_ADDR_LSB    = 0;
    localparam logic [1:0]  CFG_ADDR_RESET  = 2'h0;
    // opcodes carried in the upper nibble of the second frame byte
    localparam logic [3:0]  OP_RD_WIPER     = 4'h9;
    localparam logic [3:0]  OP_WR_WIPER     = 4'hA;
    localparam logic [3:0]  OP_RD_STORED    = 4'hB;
    localparam logic [3:0]  OP_WR_STORED    = 4'hC;
    localparam logic [3:0]  OP_TO_WIPER     = 4'hD;
    localparam logic [3:0]  OP_TO_STORED    = 4'hE;
    localparam logic [3:0]  OP_STEP         = 4'h2;
    localparam logic [3:0]  OP_ALL_TO_WIPER = 4'h1;
    localparam logic [3:0]  OP_ALL_TO_STORE = 4'h8;
    // frame lengths in serial clock pulses
    localparam logic [8:0]  HEAD_BITS       = 9'h010;
    localparam logic [8:0]  DATA_BITS       = 9'h018;
    // serial clock timing
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          SCK_PERIOD_NS   = 800;
    localparam int          SCK_HALF_CYCLES = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    // link sequencer states
    typedef enum logic [3:0] {
        LK_IDLE   = 4'b0001,
        LK_LOW    = 4'b0010,
        LK_HIGH   = 4'b0100,
        LK_FINISH = 4'b1000
    } link_state_t;
endpackage
